// ### common/spisb_pkg.sv
/*
  spisb_pkg: constants shared by the serial slave byte port and its fifo.
  assumes nothing of its surroundings beyond a systemverilog tool.
*/
package spisb_pkg;
  localparam int          SPISB_BYTE_W      = 8;
  localparam int          SPISB_CNT_W       = 3;
  localparam int          SPISB_FIFO_DEPTH  = 8;
  localparam int          SPISB_PTR_W       = 3;
  localparam logic [2:0]  SPISB_CNT_RST     = 3'h0;
  localparam logic [2:0]  SPISB_CNT_LAST    = 3'h7;
  localparam logic [7:0]  SPISB_BYTE_RST    = 8'h00;
  localparam logic [7:0]  SPISB_IDLE_FILL   = 8'h00;
  localparam logic        SPISB_MISO_RST    = 1'b0;
  localparam logic        SPISB_SEL_IDLE    = 1'b1;
  localparam logic        SPISB_SCK_IDLE    = 1'b0;
endpackage

// ### rtl/spisb_port.sv
/*
  spisb_port: serial slave byte port with receive and transmit fifos.
  holds the link-side shifters clocked by the master's serial clock, the
  crossings into the system clock and an 8-word fifo in each data path.
  assumes the master keeps select, clock and data per the usual slave timing,
  and that the serial clock stands still outside frames.
*/
//
// Overview of operation
// - device is slave only, never clocks
// - exactly four wires: select, clock, mosi, miso
// - master drives select, clock, mosi; device miso
// - capture mosi on falling clock edge
// - update miso on rising clock edge
// - one bit each way per cycle, eight per byte
// - miso always driven, never high impedance
// - select and clock readable as general inputs
`timescale 1ns/100ps

module spisb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int PTR_W = 3
) (
  input  wire logic             mclk_i,     // system clock
  input  wire logic             resetn_i,   // async reset, active low
  input  wire logic             ce_i,       // clock enable
  input  wire logic [WIDTH-1:0] in_data_i,  // write data
  input  wire logic             in_valid_i, // write request
  output      logic             in_ready_o, // not full
  output      logic [WIDTH-1:0] out_data_o, // head word
  output      logic             out_valid_o,// not empty
  input  wire logic             out_ready_i // head consumed
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [PTR_W:0]   cnt_q;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;

  wire              full  = (cnt_q == (PTR_W+1)'(DEPTH));
  wire              empty = (cnt_q == '0);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_q[rd_q];

  always_ff @(posedge mclk_i) begin
    if (ce_i && push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      if (push) wr_q <= wr_q + PTR_W'(1);
      if (pop) rd_q <= rd_q + PTR_W'(1);
      cnt_q <= cnt_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule

// two-flop synchroniser; only the second flop is visible outside
module spisb_sync #(
  parameter int   WIDTH   = 1,
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic             mclk_i,   // destination clock
  input  wire logic             resetn_i, // async reset, active low
  input  wire logic             ce_i,     // clock enable
  input  wire logic [WIDTH-1:0] async_i,  // level from another domain
  output      logic [WIDTH-1:0] sync_o    // second flop, safe to read
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= {WIDTH{RST_VAL}};
      sync_o <= {WIDTH{RST_VAL}};
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// link side shifters, clocked by the master's serial clock
module spisb_link
  import spisb_pkg::*;
(
  input  wire logic                               sck_i,    // serial clock from master
  input  wire logic                               ss_n_i,   // slave select, active low
  input  wire logic                               resetn_i, // async reset, active low
  input  wire logic                               mosi_i,   // master-out data
  output      logic                               miso_o,   // master-in data
  output      logic [spisb_pkg::SPISB_BYTE_W-1:0] rbuf_o,   // last complete byte
  output      logic                               rtog_o,   // toggles per complete byte
  input  wire logic [spisb_pkg::SPISB_BYTE_W-1:0] tbuf_i,   // word offered by system side
  input  wire logic                               tld_i,    // toggles when tbuf holds a new word
  output      logic                               tack_o    // toggles when a word is taken
);
  import spisb_pkg::*;

  logic [2:0] rcnt_q;
  logic [6:0] rsh_q;
  logic [7:0] rbuf_q;
  logic       rtog_q;
  logic [2:0] tcnt_q;
  logic [7:0] tsh_q;
  logic       miso_q;
  logic       tack_q;
  wire        lrst_n = resetn_i && !ss_n_i;
  // the serial clock stops between frames, so a synchroniser on it would lag a whole byte;
  // tbuf is written one system cycle before tld toggles and holds until the toggle is answered
  wire        tword_new = (tld_i != tack_q);

  always_ff @(negedge sck_i or negedge lrst_n) begin
    if (!lrst_n) begin
      rcnt_q <= SPISB_CNT_RST;
      rsh_q  <= '0;
    end else begin
      rcnt_q <= rcnt_q + 3'h1;
      rsh_q  <= {rsh_q[5:0], mosi_i};
    end
  end

  // completed byte survives select release; only the full reset clears it
  always_ff @(negedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rbuf_q <= SPISB_BYTE_RST;
      rtog_q <= 1'b0;
    end else if (!ss_n_i && rcnt_q == SPISB_CNT_LAST) begin
      rbuf_q <= {rsh_q, mosi_i};
      rtog_q <= ~rtog_q;
    end
  end

  always_ff @(posedge sck_i or negedge lrst_n) begin
    if (!lrst_n) begin
      tcnt_q <= SPISB_CNT_RST;
      tsh_q  <= SPISB_IDLE_FILL;
    end else begin
      tcnt_q <= tcnt_q + 3'h1;
      if (tcnt_q == SPISB_CNT_RST) begin
        tsh_q <= tword_new ? {tbuf_i[6:0], 1'b0} : {SPISB_IDLE_FILL[6:0], 1'b0};
      end else begin
        tsh_q <= {tsh_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      miso_q <= SPISB_MISO_RST;
      tack_q <= 1'b0;
    end else if (!ss_n_i) begin
      if (tcnt_q == SPISB_CNT_RST) begin
        miso_q <= tword_new ? tbuf_i[7] : SPISB_IDLE_FILL[7];
        if (tword_new) tack_q <= ~tack_q;
      end else begin
        miso_q <= tsh_q[7];
      end
    end
  end

  // holds last bit after select rises, no tristate path exists
  assign miso_o = miso_q;
  assign rbuf_o = rbuf_q;
  assign rtog_o = rtog_q;
  assign tack_o = tack_q;
endmodule

module spisb_port
  import spisb_pkg::*;
(
  input  wire logic                          mclk_i,        // system clock, 50 MHz
  input  wire logic                          resetn_i,      // async reset, active low
  input  wire logic                          ce_i,          // clock enable, freezes system-side state when low; link shifters keep running
  input  wire logic                          sck_i,         // serial clock from master
  input  wire logic                          ss_n_i,        // slave select, active low
  input  wire logic                          mosi_i,        // master-out data
  output      logic                          miso_o,        // master-in data, always driven
  output      logic [spisb_pkg::SPISB_BYTE_W-1:0] rx_data_o, // received byte
  output      logic                          rx_valid_o,    // received byte waiting
  input  wire logic                          rx_ready_i,    // received byte taken
  input  wire logic [spisb_pkg::SPISB_BYTE_W-1:0] tx_data_i, // byte to send
  input  wire logic                          tx_valid_i,    // byte offered
  output      logic                          tx_ready_o,    // tx fifo has room
  output      logic                          rx_overrun_o,  // byte lost, rx fifo full
  output      logic                          general_input_bit_zero_o, // select pin level
  output      logic                          general_input_bit_one_o   // clock pin level
);
  import spisb_pkg::*;

  logic [7:0] rbuf;      // link domain, stable for a whole byte after its toggle
  logic       rtog;      // link toggle: byte complete
  logic       tack;      // link toggle: word consumed
  logic [7:0] tbuf_q;    // system domain, stable while link reads it
  logic       tfull_q;   // system domain, word loaded flag
  logic       tld_q;     // system toggle: new word loaded

  spisb_link u_link (
    .sck_i    (sck_i),
    .ss_n_i   (ss_n_i),
    .resetn_i (resetn_i),
    .mosi_i   (mosi_i),
    .miso_o   (miso_o),
    .rbuf_o   (rbuf),
    .rtog_o   (rtog),
    .tbuf_i   (tbuf_q),
    .tld_i    (tld_q),
    .tack_o   (tack)
  );

  // system domain synchronisers, reset to the idle level so no false edge follows reset
  logic rtog_s;
  logic rtog_s_q;
  logic tack_s;

  spisb_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) u_sync_rtog (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .async_i  (rtog),
    .sync_o   (rtog_s)
  );

  spisb_sync #(
    .WIDTH   (1),
    .RST_VAL (SPISB_SEL_IDLE)
  ) u_sync_sel (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .async_i  (ss_n_i),
    .sync_o   (general_input_bit_zero_o)
  );

  spisb_sync #(
    .WIDTH   (1),
    .RST_VAL (SPISB_SCK_IDLE)
  ) u_sync_sck (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .async_i  (sck_i),
    .sync_o   (general_input_bit_one_o)
  );

  spisb_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) u_sync_tack (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .async_i  (tack),
    .sync_o   (tack_s)
  );

  // rx byte crossing: rbuf stable for many system cycles after toggle
  wire       rx_evt = rtog_s != rtog_s_q;
  logic      rxf_in_ready;
  logic [7:0] rbuf_cap_q;
  logic      rbuf_v_q;
  logic      ovr_q;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rbuf_cap_q <= SPISB_BYTE_RST;
      rbuf_v_q   <= 1'b0;
      ovr_q      <= 1'b0;
      rtog_s_q   <= 1'b0;
    end else if (ce_i) begin
      rtog_s_q <= rtog_s;
      rbuf_v_q <= rx_evt;
      if (rx_evt) rbuf_cap_q <= rbuf;
      ovr_q <= rbuf_v_q && !rxf_in_ready;
    end
  end

  assign rx_overrun_o = ovr_q;

  spisb_fifo #(
    .WIDTH (SPISB_BYTE_W),
    .DEPTH (SPISB_FIFO_DEPTH),
    .PTR_W (SPISB_PTR_W)
  ) u_rxf (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .ce_i        (ce_i),
    .in_data_i   (rbuf_cap_q),
    .in_valid_i  (rbuf_v_q),
    .in_ready_o  (rxf_in_ready),
    .out_data_o  (rx_data_o),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i)
  );

  // tx path: fifo feeds one holding word handed to the link by toggles
  logic [7:0] txf_data;
  logic       txf_valid;
  wire        tbuf_free = (tld_q == tack_s);
  wire        tx_pop    = txf_valid && tbuf_free && !tfull_q;

  spisb_fifo #(
    .WIDTH (SPISB_BYTE_W),
    .DEPTH (SPISB_FIFO_DEPTH),
    .PTR_W (SPISB_PTR_W)
  ) u_txf (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .ce_i        (ce_i),
    .in_data_i   (tx_data_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (txf_data),
    .out_valid_o (txf_valid),
    .out_ready_i (tx_pop)
  );

  // tbuf only changes while the link has acknowledged the previous word
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tbuf_q  <= SPISB_IDLE_FILL;
      tld_q   <= 1'b0;
      tfull_q <= 1'b0;
    end else if (ce_i) begin
      tfull_q <= 1'b0;
      if (tx_pop) begin
        tbuf_q  <= txf_data;
        tfull_q <= 1'b1;
      end
      if (tfull_q) tld_q <= ~tld_q;
    end
  end
endmodule

// ### bench/spisb_port_chk.sv
/*
  spisb_port_chk: assertions on the ports of the serial slave byte port.
  assumes it is bound into spisb_port and sees only its ports.
*/
`timescale 1ns/100ps
module spisb_port_chk (
  input wire logic mclk_i,                   // system clock
  input wire logic resetn_i,                 // reset, active low
  input wire logic ss_n_i,                   // select pin
  input wire logic sck_i,                    // serial clock pin
  input wire logic rx_ready_i,               // rx pop
  input wire logic miso_o,                   // serial out
  input wire logic rx_valid_o,               // rx waiting
  input wire logic tx_ready_o,               // tx room
  input wire logic rx_overrun_o,             // byte lost
  input wire logic general_input_bit_zero_o, // select level
  input wire logic general_input_bit_one_o   // clock level
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // two synchroniser flops, so the pin level shows exactly two edges later
  a_sel_pin_sync: assert property (general_input_bit_zero_o == $past(ss_n_i, 2))
    else $error("select input bit does not follow its pin");
  a_clk_pin_sync: assert property (general_input_bit_one_o == $past(sck_i, 2))
    else $error("clock input bit does not follow its pin");
  a_idle_miso_held: assert property (ss_n_i && $past(ss_n_i) |-> $stable(miso_o))
    else $error("serial out moved while deselected");
  a_reset_out_state: assert property ($rose(resetn_i) |-> !rx_valid_o && tx_ready_o && !miso_o)
    else $error("outputs wrong after reset");
  a_overrun_one_cycle: assert property (rx_overrun_o |=> !rx_overrun_o)
    else $error("overrun pulse too long");
  a_overrun_when_full: assert property (rx_overrun_o |-> rx_valid_o)
    else $error("overrun with empty rx buffer");
  a_rx_word_stands: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o)
    else $error("rx word vanished unpopped");
  a_rx_pop_only: assert property ($fell(rx_valid_o) |-> $past(rx_ready_i))
    else $error("rx valid fell without pop");
endmodule

bind spisb_port spisb_port_chk chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .ss_n_i(ss_n_i), .sck_i(sck_i),
  .rx_ready_i(rx_ready_i), .miso_o(miso_o), .rx_valid_o(rx_valid_o), .tx_ready_o(tx_ready_o),
  .rx_overrun_o(rx_overrun_o), .general_input_bit_zero_o(general_input_bit_zero_o),
  .general_input_bit_one_o(general_input_bit_one_o));

// ### bench/spisb_master.sv
/*
  spisb_master: behavioural serial bus master facing the slave port.
  assumes the caller starts a frame off the system clock edges.
*/
`timescale 1ns/100ps
module spisb_master (
  output logic      sck_o,  // serial clock
  output logic      ss_n_o, // select, active low
  output logic      mosi_o, // data to slave
  input  wire logic miso_i  // data from slave
);
  initial begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // nb below 8 cuts the frame short to exercise the discard path
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    ss_n_o = 1'b0;
    #19;
    for (int i = 7; i > 7 - nb; i--) begin
      sck_o = 1'b1;
      mosi_o = tx[i];
      #16 rx[i] = miso_i;
      sck_o = 1'b0;
      #16;
    end
    ss_n_o = 1'b1;
    // no pull on the data line, so a released line must not look valid
    mosi_o = ~mosi_o;
  endtask
endmodule

// ### bench/spisb_port_tb_top.sv
/*
  spisb_port_tb_top: self-checking bench for the serial slave byte port.
  assumes the master model and checker are compiled before it.
*/
`timescale 1ns/100ps
module spisb_port_tb_top;
  import spisb_pkg::*;
  logic       mclk_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       rx_ready_i = 1'b0;
  logic       tx_valid_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic       sck, ss_n, mosi, miso, rx_valid, tx_ready, ovr, sel_lvl, sck_lvl;
  logic [7:0] rx_data, got;
  logic       ovr_seen = 1'b0;
  int         error_cnt = 0;
  int         check_count = 0;
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (ovr) ovr_seen <= 1'b1;
  spisb_master master (.sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi), .miso_i(miso));
  spisb_port dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(1'b1), .sck_i(sck), .ss_n_i(ss_n),
    .mosi_i(mosi), .miso_o(miso), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready_i),
    .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready), .rx_overrun_o(ovr),
    .general_input_bit_zero_o(sel_lvl), .general_input_bit_one_o(sck_lvl));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic frame(input logic [7:0] tx, input int nb);
    @(posedge mclk_i);
    #3 master.xfer(tx, nb, got);
  endtask
  task automatic pop_all(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk_i);
      for (int w = 0; w < 20 && rx_valid !== 1'b1; w++) @(negedge mclk_i);
      chk("rx_valid", 8'h01, {7'h0, rx_valid});
      chk("rx_data", base + 8'(i), rx_data);
      @(posedge mclk_i) rx_ready_i <= 1'b1;
      @(posedge mclk_i) rx_ready_i <= 1'b0;
    end
  endtask
  task automatic t_stream();
    for (int i = 0; i < 10; i++) begin
      tx_data_i <= 8'(i + 1);
      tx_valid_i <= 1'b1;
      @(posedge mclk_i);
    end
    tx_valid_i <= 1'b0;
    @(negedge mclk_i);
    chk("tx_ready", 8'h00, {7'h0, tx_ready});
    repeat (6) @(posedge mclk_i);
    for (int i = 0; i < 10; i++) begin
      frame(8'h10 + 8'(i), 8);
      chk("miso_byte", (i < 9) ? 8'(i + 1) : SPISB_IDLE_FILL, got);
    end
    repeat (10) @(posedge mclk_i);
    chk("overrun", 8'h01, {7'h0, ovr_seen});
    pop_all(8, 8'h10);
  endtask
  task automatic t_partial();
    frame(8'hff, 3);
    frame(8'hc5, 8);
    chk("miso_byte", SPISB_IDLE_FILL, got);
    pop_all(1, 8'hc5);
    @(negedge mclk_i);
    chk("rx_valid", 8'h00, {7'h0, rx_valid});
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(negedge mclk_i);
    chk("reset_state", 8'h0a, {3'h0, rx_valid, tx_ready, miso, sel_lvl, sck_lvl});
    t_stream();
    t_partial();
    give_verdict();
  end
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule
